//--- core/iat_top.sv
// address translator recovery logic with its address log fifo

// ****************************************
// fifo
// ****************************************
module iat_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_q;
    logic [AW:0] rdPtr_q;

    // full when pointers differ only in the wrap bit
    assign inReady = !((wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]));
    assign outValid = wrPtr_q != rdPtr_q;
    assign outData = mem[rdPtr_q[AW-1:0]];

    // storage
    always_ff @(posedge clk)
    begin
        if (inValid && inReady)
        begin
            mem[wrPtr_q[AW-1:0]] <= inData;
        end
    end

    // pointers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end
        else
        begin
            if (inValid && inReady)
                wrPtr_q <= wrPtr_q + 1'b1;
            if (outValid && outReady)
                rdPtr_q <= rdPtr_q + 1'b1;
        end
    end
endmodule

// ****************************************
// translator core
// ****************************************
module iat_top import iat_pkg::*; #(
    parameter int unsigned STUCK_CYCLES = STUCK_CYC,
    parameter int unsigned IDLE_CYCLES = IDLE_CYC,
    parameter int FIFO_DEPTH = LOG_DEPTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // upstream bus
    input wire logic upstreamClockLine,
    input wire logic upstreamDataIn,
    output logic upstreamDataOut,
    output logic upstreamDataOe,
    // downstream bus
    input wire logic downstreamDataIn,
    output logic downstreamDataOut,
    output logic downstreamDataOe,
    output logic downstreamClockOut,
    output logic downstreamClockOe,
    // configuration
    input wire logic [3:0] lowerTranslationConfigInput,
    input wire logic [2:0] upperTranslationConfigInput,
    input wire logic upperConfigHigh,
    // status
    output logic ready,
    // address log
    output logic logValid,
    output iat_log_s logData,
    input wire logic logReady,
    output logic logSpace
);
    localparam int DLY = XOR_DELAY_CYC;
    logic [1:0] rstSync_q;
    logic rst_n;
    iat_pins_s pins, meta_q, sync_q, prev_q;
    iat_state_e state_q;
    logic sclFall, sclRise, startEv, stopEv, stuck, gapDone, xorLoad, connected, fwd;
    logic [7:0] tb, raw_q;
    logic [3:0] bitCnt_q;
    logic [7:0] dlyCnt_q;
    logic [31:0] stuckCnt_q, idleCnt_q, gapCnt_q;
    logic xorBit_q, dnOe_q, upOe_q, ready_q, clkOe_q;
    logic [1:0] dnHist_q, upHist_q;

    // reset release through two flops
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            rstSync_q <= 2'h0;
        else
            rstSync_q <= {rstSync_q[0], 1'b1};
    end
    assign rst_n = rstSync_q[1];

    // pin synchronisers and edge history
    assign pins = '{upstreamClockLine, upstreamDataIn, downstreamDataIn, upperConfigHigh,
                    {upperTranslationConfigInput, lowerTranslationConfigInput}};
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= '{1'b1, 1'b1, 1'b1, 1'b0, 7'h00};
            sync_q <= '{1'b1, 1'b1, 1'b1, 1'b0, 7'h00};
            prev_q <= '{1'b1, 1'b1, 1'b1, 1'b0, 7'h00};
        end
        else
        begin
            meta_q <= pins;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // bus events seen on the upstream side
    assign sclFall = prev_q.scl && !sync_q.scl;
    assign sclRise = !prev_q.scl && sync_q.scl;
    assign startEv = sync_q.scl && prev_q.scl && prev_q.sda && !sync_q.sda;
    assign stopEv = sync_q.scl && prev_q.scl && !prev_q.sda && sync_q.sda;
    assign tb = {sync_q.cfg, 1'b0};
    assign stuck = stuckCnt_q == STUCK_CYCLES - 1;
    assign gapDone = gapCnt_q == STOP_GAP_CYC - 1;
    assign xorLoad = dlyCnt_q == 8'h01;
    assign connected = !(state_q inside {S_BOOT, S_HOLD, S_REL});

    // translation sequencer
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= S_BOOT;
        else if (sync_q.pass)
            state_q <= S_IDLE;
        else
        begin
            case (state_q)
                S_BOOT: if (stopEv || idleCnt_q == IDLE_CYCLES - 1) state_q <= S_IDLE;
                S_IDLE: if (startEv) state_q <= S_ADDR;
                S_ADDR:
                begin
                    if (stopEv)
                        state_q <= xorBit_q ? S_HOLD : S_IDLE;
                    else if (startEv)
                        state_q <= S_WAIT;
                    else if (stuck)
                        state_q <= S_IDLE;
                    else if (sclFall && bitCnt_q == ADDR_BITS)
                        state_q <= S_DATA;
                end
                S_DATA: if (stopEv) state_q <= S_IDLE; else if (startEv) state_q <= S_ADDR;
                S_WAIT: if (stopEv) state_q <= S_IDLE;
                S_HOLD: if (gapDone) state_q <= S_REL;
                S_REL: if (gapDone) state_q <= S_IDLE;
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // bit count and raw address capture on clock rise
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bitCnt_q <= 4'h0;
            raw_q <= 8'h00;
        end
        else if (startEv)
            bitCnt_q <= 4'h0;
        else if (state_q == S_ADDR && sclRise)
        begin
            bitCnt_q <= bitCnt_q + 4'h1;
            raw_q <= {raw_q[6:0], sync_q.sda};
        end
    end

    // delay from clock fall to the translating bit change
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            dlyCnt_q <= 8'h00;
        else if (state_q == S_ADDR && sclFall && bitCnt_q < ADDR_BITS)
            dlyCnt_q <= 8'(DLY);
        else if (dlyCnt_q != 8'h00)
            dlyCnt_q <= dlyCnt_q - 8'h01;
    end

    // active translating bit, held through a stray start so a one keeps inverting
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            xorBit_q <= 1'b0;
        else if ((state_q != S_ADDR && state_q != S_WAIT) || stopEv || stuck || sync_q.pass)
            xorBit_q <= 1'b0;
        else if (xorLoad && state_q == S_ADDR)
            xorBit_q <= tb[3'(7 - bitCnt_q)];
    end

    // stuck clock, startup idle and own stop gap timers
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stuckCnt_q <= 32'h0;
            idleCnt_q <= 32'h0;
            gapCnt_q <= 32'h0;
        end
        else
        begin
            stuckCnt_q <= (state_q != S_ADDR || sclFall || sclRise) ? 32'h0 : stuckCnt_q + 32'h1;
            idleCnt_q <= (state_q == S_BOOT && sync_q.scl && sync_q.sda && sync_q.dsda)
                ? idleCnt_q + 32'h1 : 32'h0;
            gapCnt_q <= (state_q inside {S_HOLD, S_REL}) && !gapDone ? gapCnt_q + 32'h1 : 32'h0;
        end
    end

    // open-drain drivers with ownership guard against echo lockup
    assign fwd = sync_q.sda ^ xorBit_q;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dnOe_q <= 1'b0;
            upOe_q <= 1'b0;
            dnHist_q <= 2'h0;
            upHist_q <= 2'h0;
            clkOe_q <= 1'b0;
            ready_q <= 1'b0;
        end
        else
        begin
            dnOe_q <= state_q == S_HOLD || (connected && !fwd && !upOe_q && upHist_q == 2'h0);
            upOe_q <= connected && state_q != S_ADDR && !sync_q.dsda && !dnOe_q && dnHist_q == 2'h0;
            dnHist_q <= {dnHist_q[0], dnOe_q};
            upHist_q <= {upHist_q[0], upOe_q};
            clkOe_q <= connected && !sync_q.scl;
            ready_q <= connected;
        end
    end
    assign downstreamDataOe = dnOe_q;
    assign downstreamDataOut = 1'b0;
    assign upstreamDataOe = upOe_q;
    assign upstreamDataOut = 1'b0;
    assign downstreamClockOe = clkOe_q;
    assign downstreamClockOut = 1'b0;
    assign ready = ready_q;

    // log of each address byte and its translation, dropped while the log is full
    iat_fifo #(
        .WIDTH($bits(iat_log_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_log (
        .clk(core_clk),
        .rst_n(rst_n),
        .inValid(state_q == S_ADDR && sclFall && bitCnt_q == ADDR_BITS),
        .inReady(logSpace),
        .inData({raw_q, raw_q ^ tb}),
        .outValid(logValid),
        .outReady(logReady),
        .outData(logData)
    );

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence seqAbortOne;
        state_q == S_ADDR && stopEv && xorBit_q && !sync_q.pass;
    endsequence
    sequence seqOwnStop;
        state_q == S_REL && gapDone && !sync_q.pass ##1 state_q == S_IDLE;
    endsequence

    chk_start_inverted: assert property (state_q == S_ADDR && startEv && xorBit_q |=> (!dnOe_q)[*4])
        else $error("start with bit one not shown as stop");
    chk_start_passed: assert property (state_q == S_ADDR && startEv && !xorBit_q && !upOe_q
        && upHist_q == 2'h0 |=> dnOe_q)
        else $error("start with bit zero not passed");
    chk_wait_reset: assert property (state_q == S_WAIT && stopEv && !sync_q.pass |=> state_q == S_IDLE)
        else $error("no reset at stop after stray start");
    chk_abort_zero: assert property (state_q == S_ADDR && stopEv && !xorBit_q && !sync_q.pass
        |=> state_q == S_IDLE && !dnOe_q)
        else $error("early stop with bit zero not forwarded");
    chk_forced_stop: assert property (seqAbortOne |=> (state_q == S_HOLD && !clkOe_q)[*2] ##1 dnOe_q)
        else $error("forced stop hold missing");
    chk_reconnect_idle: assert property (seqOwnStop |=> ready_q && !dnOe_q)
        else $error("not reconnected after own stop");
    chk_stuck_abort: assert property (state_q == S_ADDR && stuck && !stopEv && !startEv && !sync_q.pass
        |=> state_q == S_IDLE && !xorBit_q)
        else $error("stuck clock not handled");
    chk_bit_delay: assert property (state_q == S_ADDR && sclFall && bitCnt_q < ADDR_BITS
        |-> ##(DLY) (xorLoad || state_q != S_ADDR || sclFall))
        else $error("translating bit delay wrong");
    chk_pass_through: assert property (sync_q.pass |=> state_q == S_IDLE ##1 !xorBit_q)
        else $error("pass-through did not stop translation");
    chk_boot_idle: assert property (state_q == S_BOOT && stopEv && !sync_q.pass |=> state_q == S_IDLE)
        else $error("stop did not end startup wait");
    chk_invert_data: assert property (connected && !upOe_q && upHist_q == 2'h0 && state_q != S_HOLD
        |=> dnOe_q == !$past(fwd))
        else $error("forwarded data not per active bit");
endmodule

//--- core/iat_pkg.sv
// constants and carrier types of the address translator recovery logic
//
// Behaviour
// - START in address byte, bit one: STOP downstream
// - START in address byte, bit zero: passed unchanged
// - after unexpected START, reset at next STOP
// - STOP in address byte aborts, STOP reaches downstream
// - early STOP with bit zero forwarded unchanged
// - early STOP, bit one: isolate, wait, drive STOP
// - after own STOP reconnect, idle until START
// - clock without edges over 30 ms is stuck
// - stuck bus: abort, reconnect data, await START
// - translating bit changes 100 ns after clock fall
// - upper config high: stop translating, stay connected
// - idle after STOP or lines high 120 us
package iat_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned XOR_DELAY_NS = 100;
    localparam int unsigned XOR_DELAY_CYC = (XOR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STUCK_MS = 30;
    localparam int unsigned STUCK_CYC = STUCK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned IDLE_US = 120;
    localparam int unsigned IDLE_CYC = (IDLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STOP_GAP_NS = 1000;
    localparam int unsigned STOP_GAP_CYC = (STOP_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************
    // address byte layout
    // ****************************************
    localparam logic [3:0] ADDR_BITS = 4'h8;
    localparam logic [2:0] RW_BIT_POS = 3'h0;
    localparam int unsigned LOG_DEPTH = 16;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        S_BOOT = 3'h0,
        S_IDLE = 3'h1,
        S_ADDR = 3'h3,
        S_DATA = 3'h2,
        S_WAIT = 3'h6,
        S_HOLD = 3'h7,
        S_REL = 3'h5
    } iat_state_e;

    typedef struct packed {
        logic scl;
        logic sda;
        logic dsda;
        logic pass;
        logic [6:0] cfg;
    } iat_pins_s;

    typedef struct packed {
        logic [7:0] raw;
        logic [7:0] fwd;
    } iat_log_s;

endpackage

//--- test/iat_bus_model.sv
// bus partner: upstream master and passive downstream slave
module iat_bus_model (
    // placing clock
    input wire logic core_clk,
    // device side
    input wire logic upstreamDataOe,
    input wire logic downstreamDataOe,
    // wires
    output logic upstreamClockLine,
    output logic upstreamDataIn,
    output logic downstreamDataIn
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // open-drain wires with pull-ups
    // ****************************************
    localparam real HALF = 62.5;
    logic mScl = 1'b1;
    logic mSda = 1'b1;
    // clock stands high between frames
    assign upstreamClockLine = mScl;
    assign upstreamDataIn = mSda & ~upstreamDataOe;
    assign downstreamDataIn = ~downstreamDataOe;
    // one half period, then move both master lines
    task automatic lines(input logic scl, input logic sda);
        #(HALF);
        @(negedge core_clk);
        mScl = scl;
        mSda = sda;
    endtask
    // master uses plain 7-bit addressing only, no checksum byte
    task automatic startCond();
        lines(1'b1, 1'b1);
        lines(1'b1, 1'b0);
        lines(1'b0, 1'b0);
    endtask
    task automatic stopCond();
        lines(1'b0, 1'b0);
        lines(1'b1, 1'b0);
        lines(1'b1, 1'b1);
    endtask
    // low phase stretched so the delayed translating bit settles
    task automatic sendBit(input logic b, output logic seen);
        lines(1'b0, b);
        lines(1'b1, b);
        #(HALF);
        seen = downstreamDataIn;
        lines(1'b0, b);
    endtask
endmodule

//--- test/iat_top_bench.sv
// self-checking bench of the translator recovery logic
module iat_top_bench import iat_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // signals
    // ****************************************
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [6:0] cfg = 7'h00;
    logic pass = 1'b0;
    logic logReady = 1'b0;
    logic upClk, upData, upOut, upOe, dnData, dnOut, dnOe, dnClkOut, dnClkOe;
    logic ready, logValid, logSpace;
    iat_log_s logData;
    int n_mismatch = 0;
    int checks_done = 0;
    logic [15:0] expQ[$];
    // design and partner
    iat_top #(.STUCK_CYCLES(200), .IDLE_CYCLES(50), .FIFO_DEPTH(16)) dut (
        .core_clk(core_clk), .reset_n(reset_n),
        .upstreamClockLine(upClk), .upstreamDataIn(upData),
        .upstreamDataOut(upOut), .upstreamDataOe(upOe),
        .downstreamDataIn(dnData), .downstreamDataOut(dnOut), .downstreamDataOe(dnOe),
        .downstreamClockOut(dnClkOut), .downstreamClockOe(dnClkOe),
        .lowerTranslationConfigInput(cfg[3:0]), .upperTranslationConfigInput(cfg[6:4]),
        .upperConfigHigh(pass), .ready(ready),
        .logValid(logValid), .logData(logData), .logReady(logReady), .logSpace(logSpace)
    );
    iat_bus_model bm (
        .core_clk(core_clk), .upstreamDataOe(upOe), .downstreamDataOe(dnOe),
        .upstreamClockLine(upClk), .upstreamDataIn(upData), .downstreamDataIn(dnData)
    );
    // 250 MHz clock
    initial
    begin
        forever #2 core_clk = ~core_clk;
    end
    // ****************************************
    // helpers
    // ****************************************
    task automatic tally_and_finish();
        if (n_mismatch == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // bounded wait for ready (sel 1) or downstream data (sel 0)
    task automatic waitFor(input bit sel, input logic lvl, input int lim);
        int i;
        for (i = 0; i < lim; i++)
        begin
            @(negedge core_clk);
            if ((sel ? ready : dnData) === lvl)
                break;
        end
        check({15'h0, i < lim}, 16'h1);
        if (i >= lim)
            tally_and_finish();
    endtask
    // forwarded bit: address bits flipped by the config, r/w bit untouched
    function automatic logic expBit(logic [7:0] a, logic [6:0] c, int k);
        return a[7-k] ^ ((k < 7 && !pass) ? c[6-k] : 1'b0);
    endfunction
    task automatic msgByte(input logic [7:0] a, input logic [6:0] c);
        logic seen;
        @(negedge core_clk);
        cfg = c;
        bm.startCond();
        for (int k = 0; k < 8; k++)
        begin
            bm.sendBit(a[7-k], seen);
            check({15'h0, seen}, {15'h0, expBit(a, c, k)});
        end
        bm.sendBit(1'b1, seen);
        bm.stopCond();
    endtask
    // START (isStop 0) or STOP (isStop 1) inside bit 2 of the address
    task automatic early(input bit isStop, input logic c);
        logic seen;
        logic pre;
        pre = ~isStop;
        @(negedge core_clk);
        cfg = {7{c}};
        bm.startCond();
        bm.sendBit(1'b1, seen);
        bm.sendBit(1'b0, seen);
        bm.lines(1'b0, pre);
        bm.lines(1'b1, pre);
        repeat (40) @(negedge core_clk);
        check({15'h0, dnData}, {15'h0, pre ^ c});
        bm.lines(1'b1, ~pre);
        waitFor(0, ~pre ^ c, 40);
        if (isStop && c)
        begin
            waitFor(1, 1'b0, 40);
            check({15'h0, dnData}, 16'h0);
            check({15'h0, dnClkOe}, 16'h0);
            waitFor(0, 1'b1, 800);
            waitFor(1, 1'b1, 800);
        end
        if (!isStop)
            bm.stopCond();
    endtask
    // pop every entry, comparing against the queue when asked
    task automatic drain(input bit verify, output int n);
        n = 0;
        repeat (40)
        begin
            @(negedge core_clk);
            logReady = (logValid === 1'b1);
            if (logReady)
            begin
                n++;
                if (verify)
                    check(logData, expQ.pop_front());
            end
        end
        @(negedge core_clk);
        logReady = 1'b0;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        int n;
        logic seen;
        logic [7:0] a;
        logic [6:0] c;
        void'($urandom(82));
        repeat (2) @(negedge core_clk);
        check({15'h0, ready}, 16'h0);
        reset_n = 1'b1;
        waitFor(1, 1'b1, 200);
        pass = 1'b1;
        msgByte(8'hA4, 7'h7F);
        check({15'h0, ready}, 16'h1);
        pass = 1'b0;
        drain(0, n);
        early(0, 1'b1);
        early(0, 1'b0);
        early(1, 1'b0);
        early(1, 1'b1);
        // clock parked low mid-address, then data must pass straight through
        cfg = 7'h7F;
        bm.startCond();
        bm.sendBit(1'b1, seen);
        bm.sendBit(1'b1, seen);
        repeat (300) @(negedge core_clk);
        bm.lines(1'b0, 1'b0);
        repeat (20) @(negedge core_clk);
        check({15'h0, dnData}, 16'h0);
        check({15'h0, dnClkOe}, 16'h1);
        check({13'h0, upOut, dnOut, dnClkOut}, 16'h0);
        bm.lines(1'b0, 1'b1);
        repeat (20) @(negedge core_clk);
        check({15'h0, dnData}, 16'h1);
        bm.stopCond();
        drain(0, n);
        // random addresses with corners, log filled past its depth
        for (int m = 0; m < 17; m++)
        begin
            a = (m == 0) ? 8'h00 : (m == 1) ? 8'hFF : 8'($urandom);
            c = (m == 0) ? 7'h7F : (m == 1) ? 7'h00 : 7'($urandom);
            if (m < 16)
                expQ.push_back({a, a ^ {c, 1'b0}});
            msgByte(a, c);
        end
        check({15'h0, logSpace}, 16'h0);
        drain(1, n);
        check(16'(n), 16'h0010);
        tally_and_finish();
    end
endmodule
